// [rtl/tsr_font_sel.sv]
// Font selector: picks field A or B of the font choice register by the
// attribute bit and maps the code to a font memory offset.
// Assumes all inputs are on clk; output is registered.
`timescale 1ns/10ps
module tsr_font_sel (
    input wire logic clk,
    input wire logic srst,
    input wire logic [7:0] font_choice,
    input wire logic attr_bit3,
    input wire logic ext_font_en,
    input wire logic [2:0] font_pointer,
    output logic [15:0] font_offset
);
    logic [2:0] code; // Selected three-bit font code
    logic [15:0] offset_d;
    logic [15:0] offset_q;

    // Pick source code, then map to offset in 8K units
    always_comb begin
        if (ext_font_en) begin
            code = font_pointer;
        end else if (attr_bit3) begin
            code = {font_choice[5], font_choice[3], font_choice[2]};
        end else begin
            code = {font_choice[4], font_choice[1], font_choice[0]};
        end
        // Low two bits give 16K steps, top bit adds 8K
        offset_d = {code[1:0], code[2], 13'h0000};
    end

    // Register the offset
    always_ff @(posedge clk) begin
        if (srst) begin
            offset_q <= 16'h0000;
        end else begin
            offset_q <= offset_d;
        end
    end

    assign font_offset = offset_q;

    a_font_map: assert property (@(posedge clk) disable iff (srst)
        !ext_font_en && !attr_bit3 && font_choice[4] && !font_choice[1] && !font_choice[0]
        |=> font_offset == 16'h2000)
        else $error("font code 100 must map to 8K");
    // Bypass takes the external pointer and ignores both fields
    a_font_bypass: assert property (@(posedge clk) disable iff (srst)
        ext_font_en && font_pointer == 3'h7 |=> font_offset == 16'hE000)
        else $error("bypass pointer 111 must map to 56K");
endmodule : tsr_font_sel

// [rtl/tsr_pkg.sv]
// Package for the timing sequencer register bank: port addresses, indexes,
// field positions, reset values and the decoded control bundle.
// Assumes a host I/O bus with 16-bit port address and 8-bit data.
package tsr_pkg;
    // Host port addresses
    localparam logic [15:0] INDEX_PORT_ADDR = 16'h03C4;
    localparam logic [15:0] DATA_PORT_ADDR = 16'h03C5;
    // Indexes of the indexed registers
    localparam logic [2:0] IDX_RESET_CTRL = 3'h0;
    localparam logic [2:0] IDX_SEQ_MODE = 3'h1;
    localparam logic [2:0] IDX_PLANE_MASK = 3'h2;
    localparam logic [2:0] IDX_FONT_CHOICE = 3'h3;
    localparam logic [2:0] IDX_MEM_MODE = 3'h4;
    localparam logic [2:0] IDX_RESERVED = 3'h5;
    localparam logic [2:0] IDX_STATE_CTRL = 3'h6;
    localparam logic [2:0] IDX_AUX_MODE = 3'h7;
    // Writable bit masks; other bits read zero
    localparam logic [7:0] MASK_INDEX = 8'h07;
    localparam logic [7:0] MASK_RESET_CTRL = 8'h03;
    localparam logic [7:0] MASK_SEQ_MODE = 8'h3D;
    localparam logic [7:0] MASK_PLANE_MASK = 8'h0F;
    localparam logic [7:0] MASK_FONT_CHOICE = 8'h3F;
    localparam logic [7:0] MASK_MEM_MODE = 8'h0E;
    localparam logic [7:0] MASK_STATE_CTRL = 8'hF6;
    localparam logic [7:0] MASK_AUX_MODE = 8'hFD;
    // Field positions
    localparam int RST_ASYNC_BIT = 0;
    localparam int RST_SYNC_BIT = 1;
    localparam int MODE_STATE_BIT = 0;
    localparam int MODE_LOAD_HALF_BIT = 2;
    localparam int MODE_DOT_HALF_BIT = 3;
    localparam int MODE_SHIFT4_BIT = 4;
    localparam int MODE_SCREEN_OFF_BIT = 5;
    localparam int STATE_EXT_LO_BIT = 1;
    localparam int STATE_EXT_HI_BIT = 2;
    localparam int VSC_KEEP_LSB = 0;
    // Reset values
    localparam logic [7:0] RST_INDEX = 8'h00;
    localparam logic [7:0] RST_RESET_CTRL = 8'h03;
    localparam logic [7:0] RST_SEQ_MODE = 8'h00;
    localparam logic [7:0] RST_PLANE_MASK = 8'h0F;
    localparam logic [7:0] RST_FONT_CHOICE = 8'h00;
    localparam logic [7:0] RST_OTHER = 8'h00;
    // Bits 5:3 of the first video system configuration register cleared on halt
    localparam logic [7:0] VSC_HALT_CLEAR = 8'h38;
    // Width of a font memory offset (up to 56K)
    localparam int FONT_OFS_W = 16;

    // Decoded controls sent to the sequencer
    typedef struct packed {
        logic run;
        logic screen_blank;
        logic load_quarter;
        logic dot_half;
        logic load_half;
        logic [4:0] dots_per_char;
        logic [3:0] plane_we;
    } tsr_ctrl_s;
endpackage : tsr_pkg

// [rtl/tsr_regs.sv]
// Timing sequencer register bank behind an index port and a data port.
// Assumes host I/O strobes and the attribute inputs are on clk.
//
// Overview of operation
// - Index port holds three bits, steers data port
// - Indexes 0-7 map registers, 5 reserved
// - Either reset bit zero clears and halts
// - Sequencer runs only with both bits set
// - Synchronous halt clears config bits 5:3
// - Mode bit 5 blanks screen, fast access
// - Mode bit 4 loads shifter quarter rate
// - Mode bit 3 halves dot clock
// - Mode bit 2 loads latches half rate
// - Mode bit 0 picks nine or eight dots
// - Extended bits with bit 0 give dots
// - Mask bits 3:0 gate plane writes
// - Attribute bit 3 picks field A or B
// - Font code maps to font memory offset
// - Attribute register bit 7 bypasses register
`timescale 1ns/10ps
module tsr_regs (
    input wire logic clk,
    input wire logic srst,
    input wire logic [15:0] io_addr,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata,
    output logic io_rdata_valid,
    input wire logic attr_bit3,
    input wire logic attr_font_bypass,
    input wire logic [2:0] font_pointer,
    output tsr_pkg::tsr_ctrl_s seq_ctrl,
    output logic [1:0] seq_state_ext,
    output logic [2:0] seq_char_dot,
    output logic vsc_halt_clear,
    output logic [15:0] font_offset,
    output logic [7:0] mem_mode,
    output logic [7:0] state_ctrl,
    output logic [7:0] aux_mode
);
    // Index plus eight indexed registers (entry 5 unused, reads zero)
    logic [7:0] index_q;
    logic [7:0] index_d;
    logic [7:0] regs_q [8];
    logic [7:0] regs_d [8];
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic rvalid_q;
    logic rvalid_d;
    logic [7:0] wmask [8]; // Writable bits per index
    logic idx_hit;
    logic dat_hit;
    tsr_pkg::tsr_ctrl_s ctrl_d;
    tsr_pkg::tsr_ctrl_s ctrl_q;
    logic halt_clr_q;
    logic [2:0] cnt_q; // Character dot phase counter
    logic [2:0] cnt_d;

    assign wmask[0] = tsr_pkg::MASK_RESET_CTRL;
    assign wmask[1] = tsr_pkg::MASK_SEQ_MODE;
    assign wmask[2] = tsr_pkg::MASK_PLANE_MASK;
    assign wmask[3] = tsr_pkg::MASK_FONT_CHOICE;
    assign wmask[4] = tsr_pkg::MASK_MEM_MODE;
    assign wmask[5] = 8'h00;
    assign wmask[6] = tsr_pkg::MASK_STATE_CTRL;
    assign wmask[7] = tsr_pkg::MASK_AUX_MODE;

    assign idx_hit = (io_addr == tsr_pkg::INDEX_PORT_ADDR);
    assign dat_hit = (io_addr == tsr_pkg::DATA_PORT_ADDR);

    // Index port: only three bits kept
    always_comb begin
        index_d = index_q;
        if (io_wr && idx_hit) begin
            index_d = io_wdata & tsr_pkg::MASK_INDEX;
        end
    end

    // Indexed registers: one loop, write lands only on the indexed entry
    generate
        for (genvar i = 0; i < 8; i++) begin : g_reg
            always_comb begin
                regs_d[i] = regs_q[i];
                if (io_wr && dat_hit && index_q[2:0] == 3'(i)) begin
                    regs_d[i] = io_wdata & wmask[i];
                end
            end
            always_ff @(posedge clk) begin
                if (srst) begin
                    regs_q[i] <= (i == 0) ? tsr_pkg::RST_RESET_CTRL :
                                 (i == 2) ? tsr_pkg::RST_PLANE_MASK : tsr_pkg::RST_OTHER;
                end else begin
                    regs_q[i] <= regs_d[i];
                end
            end
        end
    endgenerate

    // Read path: data valid one cycle after the read strobe
    always_comb begin
        rdata_d = rdata_q;
        rvalid_d = 1'b0;
        if (io_rd && idx_hit) begin
            rdata_d = index_q;
            rvalid_d = 1'b1;
        end else if (io_rd && dat_hit) begin
            rdata_d = regs_q[index_q[2:0]];
            rvalid_d = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            index_q <= tsr_pkg::RST_INDEX;
            rdata_q <= 8'h00;
            rvalid_q <= 1'b0;
        end else begin
            index_q <= index_d;
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    // Decode controls; dots per character from extended state and bit 0
    always_comb begin
        logic [2:0] sel;
        sel = {regs_q[6][tsr_pkg::STATE_EXT_HI_BIT], regs_q[6][tsr_pkg::STATE_EXT_LO_BIT],
               regs_q[1][tsr_pkg::MODE_STATE_BIT]};
        ctrl_d.run = regs_q[0][tsr_pkg::RST_ASYNC_BIT] &
                     regs_q[0][tsr_pkg::RST_SYNC_BIT];
        ctrl_d.screen_blank = regs_q[1][tsr_pkg::MODE_SCREEN_OFF_BIT];
        ctrl_d.load_quarter = regs_q[1][tsr_pkg::MODE_SHIFT4_BIT];
        ctrl_d.dot_half = regs_q[1][tsr_pkg::MODE_DOT_HALF_BIT];
        ctrl_d.load_half = regs_q[1][tsr_pkg::MODE_LOAD_HALF_BIT];
        ctrl_d.plane_we = regs_q[2][3:0];
        case (sel)
            3'h7: ctrl_d.dots_per_char = 5'h10;
            3'h4: ctrl_d.dots_per_char = 5'h0C;
            3'h3: ctrl_d.dots_per_char = 5'h0B;
            3'h2: ctrl_d.dots_per_char = 5'h0A;
            3'h1: ctrl_d.dots_per_char = 5'h08;
            3'h0: ctrl_d.dots_per_char = 5'h09;
            3'h5: ctrl_d.dots_per_char = 5'h07;
            3'h6: ctrl_d.dots_per_char = 5'h06;
            default: ctrl_d.dots_per_char = 5'h09;
        endcase
    end

    // Sequencer phase counter: cleared and frozen while halted
    always_comb begin
        if (!ctrl_q.run) begin
            cnt_d = 3'h0;
        end else begin
            cnt_d = 3'(cnt_q + 3'h1);
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            ctrl_q <= '0;
            halt_clr_q <= 1'b0;
            cnt_q <= 3'h0;
        end else begin
            ctrl_q <= ctrl_d;
            halt_clr_q <= ~regs_q[0][tsr_pkg::RST_SYNC_BIT];
            cnt_q <= cnt_d;
        end
    end

    tsr_font_sel u_font (
        .clk(clk),
        .srst(srst),
        .font_choice(regs_q[3]),
        .attr_bit3(attr_bit3),
        .ext_font_en(attr_font_bypass),
        .font_pointer(font_pointer),
        .font_offset(font_offset)
    );

    assign io_rdata = rdata_q;
    assign io_rdata_valid = rvalid_q;
    assign seq_ctrl = ctrl_q;
    assign seq_state_ext = regs_q[6][2:1];
    assign seq_char_dot = cnt_q;
    assign vsc_halt_clear = halt_clr_q;
    assign mem_mode = regs_q[4];
    assign state_ctrl = regs_q[6];
    assign aux_mode = regs_q[7];

    a_halt_stops: assert property (@(posedge clk) disable iff (srst)
        !regs_q[0][1] ##1 1'b1 |=> seq_char_dot == 3'h0)
        else $error("halted sequencer must hold zero");
    a_run_both: assert property (@(posedge clk) disable iff (srst)
        seq_ctrl.run |-> $past(regs_q[0][1:0]) == 2'h3)
        else $error("run without both reset bits");
    a_idx_write: assert property (@(posedge clk) disable iff (srst)
        io_wr && idx_hit |=> index_q == {5'h00, $past(io_wdata[2:0])})
        else $error("index port not captured");
    a_data_keeps: assert property (@(posedge clk) disable iff (srst)
        io_wr && dat_hit |=> $stable(index_q))
        else $error("data write changed index");
    a_reserved_zero: assert property (@(posedge clk) disable iff (srst)
        io_rd && dat_hit && index_q[2:0] == 3'h5 |=> io_rdata == 8'h00)
        else $error("reserved index read nonzero");
    a_halt_vsc: assert property (@(posedge clk) disable iff (srst)
        !regs_q[0][1] |=> vsc_halt_clear)
        else $error("halt did not clear config bits");
    a_blank_mode: assert property (@(posedge clk) disable iff (srst)
        regs_q[1][5] |=> seq_ctrl.screen_blank)
        else $error("screen blank not forced");
    a_dots_nine: assert property (@(posedge clk) disable iff (srst)
        regs_q[1][0] == 1'b0 && regs_q[6][2:1] == 2'h0 |=> seq_ctrl.dots_per_char == 5'h09)
        else $error("state 0 must give nine dots");
    a_plane_mask: assert property (@(posedge clk) disable iff (srst)
        1'b1 |=> seq_ctrl.plane_we == $past(regs_q[2][3:0]))
        else $error("plane enables do not follow mask");
    // The async control bit halts on its own, not only the sync bit
    a_halt_async: assert property (@(posedge clk) disable iff (srst)
        !regs_q[0][0] |=> !seq_ctrl.run)
        else $error("async bit clear did not halt");
    // A running sequencer steps its phase by one every clock
    a_run_count: assert property (@(posedge clk) disable iff (srst)
        seq_ctrl.run |=> seq_char_dot == 3'($past(seq_char_dot) + 3'h1))
        else $error("running sequencer did not advance");
    a_dots_sixteen: assert property (@(posedge clk) disable iff (srst)
        regs_q[1][0] && regs_q[6][2:1] == 2'h3 |=> seq_ctrl.dots_per_char == 5'h10)
        else $error("state 11/1 must give sixteen dots");
endmodule : tsr_regs

// [tb/tsr_host.sv]
// Host processor model: issues port writes and reads, one strobe each.
// Assumes the bench calls its tasks from a single process.
`timescale 1ns/10ps
module tsr_host (
    input wire logic clk,
    output logic [15:0] io_addr,
    output logic io_wr,
    output logic io_rd,
    output logic [7:0] io_wdata
);
    logic [7:0] exp_q [$]; // Expected read data, oldest first
    // Idle bus: nothing selected
    initial begin
        io_addr = 16'hFC3A;
        io_wr = 1'b0;
        io_rd = 1'b0;
        io_wdata = 8'h00;
    end
    // One access; released lines show inverted values so stale data never matches
    task automatic cyc(input logic [15:0] a, input logic [7:0] d, input logic w);
        @(posedge clk);
        #1;
        io_addr = a;
        io_wdata = d;
        io_wr = w;
        io_rd = ~w;
        @(posedge clk);
        #1;
        io_wr = 1'b0;
        io_rd = 1'b0;
        io_addr = ~a;
        io_wdata = ~d;
    endtask : cyc
    // Indexed write: index first, then data port
    task automatic put(input logic [7:0] idx, input logic [7:0] d);
        cyc(tsr_pkg::INDEX_PORT_ADDR, idx, 1'b1);
        cyc(tsr_pkg::DATA_PORT_ADDR, d, 1'b1);
    endtask : put
    // Indexed read; the expected value is noted before the strobe
    task automatic get(input logic [7:0] idx, input logic [7:0] e);
        cyc(tsr_pkg::INDEX_PORT_ADDR, idx, 1'b1);
        exp_q.push_back(e);
        cyc(tsr_pkg::DATA_PORT_ADDR, ~e, 1'b0);
    endtask : get
endmodule : tsr_host

// [tb/tsr_regs_tb.sv]
// Self-checking bench for the timing sequencer register bank.
// Assumes the chosen reset values and one-cycle control latency.
`timescale 1ns/10ps
module tsr_regs_tb;
    logic clk = 1'b0; // 100 MHz
    logic srst = 1'b1;
    logic attr_bit3 = 1'b0;
    logic attr_font_bypass = 1'b0;
    logic [2:0] font_pointer = 3'h0;
    logic [15:0] io_addr;
    logic io_wr, io_rd, io_rdata_valid, vsc_halt_clear;
    logic [7:0] io_wdata, io_rdata, mem_mode, state_ctrl, aux_mode;
    tsr_pkg::tsr_ctrl_s seq_ctrl;
    logic [1:0] seq_state_ext;
    logic [2:0] seq_char_dot;
    logic [15:0] font_offset;
    int fails = 0; // Mismatches
    int checks = 0; // Comparisons made
    integer seed = 32'h8957;
    // Writable bits and reset values per index; index 5 holds nothing
    logic [7:0] msk [8] = '{8'h03, 8'h3D, 8'h0F, 8'h3F, 8'h0E, 8'h00, 8'hF6, 8'hFD};
    logic [7:0] rst [8] = '{8'h03, 8'h00, 8'h0F, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    // Dots per character by {extended state, mode bit 0}
    logic [4:0] dpc [8] = '{5'h09, 5'h08, 5'h0A, 5'h0B, 5'h0C, 5'h07, 5'h06, 5'h10};
    // Font memory offset by selected code, in bytes
    logic [15:0] fofs [8] = '{16'h0000, 16'h4000, 16'h8000, 16'hC000,
        16'h2000, 16'h6000, 16'hA000, 16'hE000};
    always #5 clk = ~clk;
    tsr_host host (.clk(clk), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
        .io_wdata(io_wdata));
    tsr_regs dut (.clk(clk), .srst(srst), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
        .io_wdata(io_wdata), .io_rdata(io_rdata), .io_rdata_valid(io_rdata_valid),
        .attr_bit3(attr_bit3), .attr_font_bypass(attr_font_bypass),
        .font_pointer(font_pointer), .seq_ctrl(seq_ctrl), .seq_state_ext(seq_state_ext),
        .seq_char_dot(seq_char_dot), .vsc_halt_clear(vsc_halt_clear),
        .font_offset(font_offset), .mem_mode(mem_mode), .state_ctrl(state_ctrl),
        .aux_mode(aux_mode));
    // Compare and count
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e) begin
            fails++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // Let register and control stages land, then stand 1 ns past an edge
    task automatic wt();
        repeat (3) @(posedge clk);
        #1;
    endtask : wt
    task automatic tally_and_finish();
        if (fails == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : tally_and_finish
    // Read monitor: each valid pulse consumes the oldest expectation
    always @(negedge clk) begin
        if (io_rdata_valid === 1'b1) begin
            if (host.exp_q.size() == 0) chk("io_rdata_extra", 16'h0000, 16'hFFFF);
            else chk("io_rdata", 16'(host.exp_q.pop_front()), 16'(io_rdata));
        end
    end
    // Watchdog, far beyond the roughly 400 cycles the tests need
    initial begin
        #100000;
        fails++;
        tally_and_finish();
    end
    initial begin
        logic [7:0] d;
        logic [7:0] v [8];
        logic [2:0] c;
        logic [2:0] q;
        repeat (5) @(posedge clk);
        #1;
        srst = 1'b0;
        // Random fill, junk in the index's reserved bits
        for (int i = 0; i < 8; i++) begin
            v[i] = 8'($random(seed));
            host.put({v[i][7:3], i[2:0]}, v[i]);
        end
        host.cyc(16'h03C6, 8'hFF, 1'b1);
        host.exp_q.push_back(8'h07);
        host.cyc(tsr_pkg::INDEX_PORT_ADDR, 8'h00, 1'b0);
        for (int i = 0; i < 8; i++) host.get(i[7:0], v[i] & msk[i]);
        chk("mem_mode", 16'(v[4] & msk[4]), 16'(mem_mode));
        chk("state_ctrl", 16'(v[6] & msk[6]), 16'(state_ctrl));
        chk("aux_mode", 16'(v[7] & msk[7]), 16'(aux_mode));
        // Reset again in mid-run, then read the reset values
        srst = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        srst = 1'b0;
        for (int i = 0; i < 8; i++) host.get(i[7:0], rst[i]);
        // Every combination of the two halt bits
        for (int i = 0; i < 4; i++) begin
            host.put(8'h00, i[7:0]);
            wt();
            d = {5'h00, seq_char_dot};
            chk("run", 16'(i == 3), 16'(seq_ctrl.run));
            chk("halt_clear", 16'(!i[1]), 16'(vsc_halt_clear));
            @(posedge clk);
            #1;
            q = (i == 3) ? d[2:0] + 3'h1 : 3'h0;
            chk("char_dot", 16'(q), 16'(seq_char_dot));
        end
        // Mode flags, one at a time, under halt
        host.put(8'h00, 8'h01);
        for (int b = 2; b < 6; b++) begin
            d = 8'h01 << b;
            host.put(8'h01, d);
            wt();
            chk("mode", 16'(d[5:2]), 16'(seq_ctrl[12:9]));
        end
        for (int k = 0; k < 8; k++) begin
            host.put(8'h06, {5'h00, k[2:1], 1'b0});
            host.put(8'h01, {7'h00, k[0]});
            wt();
            chk("dots", 16'(dpc[k]), 16'(seq_ctrl.dots_per_char));
            chk("state_ext", 16'(k[2:1]), 16'(seq_state_ext));
        end
        host.put(8'h00, 8'h03);
        // Plane mask, last value all planes
        for (int i = 0; i < 4; i++) begin
            d = (i == 3) ? 8'h0F : 8'($random(seed));
            host.put(8'h02, d);
            wt();
            chk("plane_we", 16'(d[3:0]), 16'(seq_ctrl.plane_we));
        end
        // Field A holds the code, field B its inverse, pointer a third value
        for (int k = 0; k < 8; k++) begin
            c = k[2:0];
            host.put(8'h03, {2'h0, ~c[2], c[2], ~c[1:0], c[1:0]});
            for (int a = 0; a < 3; a++) begin
                attr_bit3 = a[0];
                attr_font_bypass = a[1];
                font_pointer = c ^ 3'h5;
                q = (a == 2) ? c ^ 3'h5 : (a == 1) ? ~c : c;
                wt();
                chk("font_offset", fofs[q], font_offset);
            end
        end
        wt();
        chk("pending_reads", 16'h0000, 16'(host.exp_q.size()));
        tally_and_finish();
    end
endmodule : tsr_regs_tb
